// *** hw/srt_params.svh ***
// offsets, field positions, reset values and encodings of the status transfer unit
// assumes it is included by its bare name ahead of the design module
`ifndef SRT_PARAMS_SVH
`define SRT_PARAMS_SVH

// register byte offsets on the bus
`define SRT_OFS_INSTR 8'h00
`define SRT_OFS_SRC 8'h04
`define SRT_OFS_RN 8'h08
`define SRT_OFS_STATUS 8'h0c
`define SRT_OFS_SAVED 8'h10
`define SRT_OFS_RESULT 8'h14
`define SRT_OFS_INFO 8'h18

// status word fields
`define SRT_FLAG_N 31
`define SRT_FLAG_Z 30
`define SRT_FLAG_C 29
`define SRT_FLAG_V 28
`define SRT_MODE_HI 4
`define SRT_STATUS_RESET 32'h000000d3

// mode codes
`define SRT_MODE_USER 5'h10
`define SRT_MODE_FIQ 5'h11
`define SRT_MODE_IRQ 5'h12
`define SRT_MODE_SVC 5'h13
`define SRT_MODE_ABT 5'h17
`define SRT_MODE_UND 5'h1b
`define SRT_BANKS 5

// instruction fields
`define SRT_COND_HI 31
`define SRT_COND_LO 28
`define SRT_IMM_BIT 25
`define SRT_CHOICE_BIT 22
`define SRT_WRITE_BIT 21
`define SRT_SETF_BIT 20
`define SRT_CTRL_BIT 16
`define SRT_PC_REG 4'hf
`define SRT_OP_TEST_BITS 2'h0
`define SRT_OP_TEST_EQUIV 2'h1
`define SRT_OP_COMPARE 2'h2
`define SRT_OP_COMPARE_NEG 2'h3

`endif

// *** hw/srt_pkg.sv ***
// types shared by the status transfer unit
// assumes nothing beyond a SystemVerilog compiler
package srt_pkg;
  typedef enum logic [1:0] {
    SRT_KIND_READ,
    SRT_KIND_WRITE,
    SRT_KIND_COMPARE,
    SRT_KIND_OTHER
  } srt_kind_e;
endpackage

// *** hw/srt_unit.sv ***
// status transfer unit: decodes and executes status read, status write and the
// compare/test operations that share their encoding, behind an ahb-lite slave
// assumes a single ahb-lite master, word transfers only, one clock domain
//
// Operation
// - execute only when condition field is true
// - status ops: compare/test encodings, flag bit clear
// - status read copies chosen word to result
// - status write copies register or rotated immediate into chosen word
// - flags-only write sets top four bits
// - user mode: current word control bits protected
// - privileged mode: whole current word writable
// - saved access uses bank of active mode
// - flag-setting compares update flags, no result
`timescale 1ns/1ns
`include "srt_params.svh"

module srt_unit (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // current status word for the rest of the core
  output logic [31:0] status_word
);

  // bus data phase tracking
  logic dp_valid;
  logic dp_write;
  logic [7:0] dp_addr;
  logic rd_done;

  // architectural state
  logic [31:0] cur_status;
  logic [31:0] saved_bank [`SRT_BANKS];
  logic [31:0] instr;
  logic [31:0] src_value;
  logic [31:0] rn_value;
  logic [31:0] result;
  logic [11:0] info;

  wire take_addr = hready & hsel & htrans[1];
  wire wr_phase = dp_valid & dp_write;
  wire rd_phase = dp_valid & ~dp_write;
  wire wr_instr = wr_phase & (dp_addr == `SRT_OFS_INSTR);
  wire wr_src = wr_phase & (dp_addr == `SRT_OFS_SRC);
  wire wr_rn = wr_phase & (dp_addr == `SRT_OFS_RN);

  assign hreadyout = ~(rd_phase & ~rd_done);
  assign hresp = 1'b0;
  assign status_word = cur_status;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr <= 8'h00;
      rd_done <= 1'b0;
    end else if (hready) begin
      dp_valid <= take_addr;
      dp_write <= hwrite;
      dp_addr <= {haddr[7:2], 2'b00};
      rd_done <= 1'b0;
    end else if (rd_phase) begin
      rd_done <= 1'b1;
    end
  end

  // instruction fields, taken straight from the write data so execution lands
  // in the same cycle as the bus write
  wire [31:0] ins = hwdata;
  wire [3:0] cond = ins[`SRT_COND_HI:`SRT_COND_LO];
  wire [1:0] alu_op = ins[22:21];
  wire [3:0] rn_idx = ins[19:16];
  wire [3:0] rd_idx = ins[15:12];
  wire [3:0] rm_idx = ins[3:0];
  wire is_imm = ins[`SRT_IMM_BIT];
  wire pick_saved = ins[`SRT_CHOICE_BIT];
  wire ctrl_field = ins[`SRT_CTRL_BIT];
  wire sets_flags = ins[`SRT_SETF_BIT];
  wire compare_space = (ins[27:26] == 2'b00) & (ins[24:23] == 2'b10);

  srt_pkg::srt_kind_e kind;
  assign kind = !compare_space ? srt_pkg::SRT_KIND_OTHER :
                sets_flags ? srt_pkg::SRT_KIND_COMPARE :
                !ins[`SRT_WRITE_BIT] ? srt_pkg::SRT_KIND_READ :
                srt_pkg::SRT_KIND_WRITE;

  // condition evaluation
  wire fn = cur_status[`SRT_FLAG_N];
  wire fz = cur_status[`SRT_FLAG_Z];
  wire fc = cur_status[`SRT_FLAG_C];
  wire fv = cur_status[`SRT_FLAG_V];
  logic cond_true;
  always_comb begin
    unique case (cond)
      4'h0: cond_true = fz;
      4'h1: cond_true = ~fz;
      4'h2: cond_true = fc;
      4'h3: cond_true = ~fc;
      4'h4: cond_true = fn;
      4'h5: cond_true = ~fn;
      4'h6: cond_true = fv;
      4'h7: cond_true = ~fv;
      4'h8: cond_true = fc & ~fz;
      4'h9: cond_true = ~fc | fz;
      4'ha: cond_true = (fn == fv);
      4'hb: cond_true = (fn != fv);
      4'hc: cond_true = ~fz & (fn == fv);
      4'hd: cond_true = fz | (fn != fv);
      4'he: cond_true = 1'b1;
      4'hf: cond_true = 1'b0;
    endcase
  end

  // saved bank of the active mode; user and system have none
  wire [4:0] mode = cur_status[`SRT_MODE_HI:0];
  wire user_mode = (mode == `SRT_MODE_USER);
  wire has_bank = (mode == `SRT_MODE_FIQ) | (mode == `SRT_MODE_IRQ) |
                  (mode == `SRT_MODE_SVC) | (mode == `SRT_MODE_ABT) |
                  (mode == `SRT_MODE_UND);
  wire [2:0] bank_sel = (mode == `SRT_MODE_FIQ) ? 3'h0 :
                        (mode == `SRT_MODE_IRQ) ? 3'h1 :
                        (mode == `SRT_MODE_SVC) ? 3'h2 :
                        (mode == `SRT_MODE_ABT) ? 3'h3 : 3'h4;
  wire [31:0] saved_cur = has_bank ? saved_bank[bank_sel] : 32'h00000000;

  // operand two: rotated immediate or the source register value; register
  // shifts are not modelled, so the register form passes the value unshifted
  wire [4:0] rot = {ins[11:8], 1'b0};
  wire [63:0] imm_dbl = {24'h000000, ins[7:0], 24'h000000, ins[7:0]};
  wire [31:0] imm_val = 32'(imm_dbl >> rot);
  wire [31:0] op2 = is_imm ? imm_val : src_value;
  wire shift_c = (is_imm && rot != 5'h00) ? imm_val[31] : fc;

  // compare/test arithmetic
  wire [32:0] sum_sub = {1'b0, rn_value} + {1'b0, ~op2} + 33'h000000001;
  wire [32:0] sum_add = {1'b0, rn_value} + {1'b0, op2};
  logic [31:0] alu;
  logic alu_c;
  logic alu_v;
  always_comb begin
    alu = 32'h00000000;
    alu_c = shift_c;
    alu_v = fv;
    unique case (alu_op)
      `SRT_OP_TEST_BITS: alu = rn_value & op2;
      `SRT_OP_TEST_EQUIV: alu = rn_value ^ op2;
      `SRT_OP_COMPARE: begin
        alu = sum_sub[31:0];
        alu_c = sum_sub[32];
        alu_v = (rn_value[31] != op2[31]) & (alu[31] != rn_value[31]);
      end
      `SRT_OP_COMPARE_NEG: begin
        alu = sum_add[31:0];
        alu_c = sum_add[32];
        alu_v = (rn_value[31] == op2[31]) & (alu[31] != rn_value[31]);
      end
    endcase
  end
  wire [3:0] alu_flags = {alu[31], (alu == 32'h00000000), alu_c, alu_v};

  // execution strobes
  wire go = wr_instr & cond_true;
  wire do_read = go & (kind == srt_pkg::SRT_KIND_READ);
  wire do_write = go & (kind == srt_pkg::SRT_KIND_WRITE);
  wire do_compare = go & (kind == srt_pkg::SRT_KIND_COMPARE);
  wire flags_only = ~ctrl_field;
  wire saved_fault = (do_read | do_write) & pick_saved & ~has_bank;
  wire pc_used = (do_read & (rd_idx == `SRT_PC_REG)) |
                 (do_write & ~is_imm & (rm_idx == `SRT_PC_REG)) |
                 (do_compare & (rn_idx == `SRT_PC_REG));

  // next current status word
  wire keep_ctrl = flags_only | user_mode;
  wire [31:0] write_cur = keep_ctrl ? {op2[31:28], cur_status[27:0]} : op2;
  logic [31:0] next_status;
  assign next_status = (do_write & ~pick_saved) ? write_cur :
                       do_compare ? {alu_flags, cur_status[27:0]} : cur_status;
  wire [31:0] write_saved = flags_only ? {op2[31:28], saved_cur[27:0]} : op2;
  wire bank_we = do_write & pick_saved & has_bank;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur_status <= `SRT_STATUS_RESET;
    end else begin
      cur_status <= next_status;
    end
  end

  genvar b;
  generate
    for (b = 0; b < `SRT_BANKS; b++) begin : g_bank
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          saved_bank[b] <= 32'h00000000;
        end else if (bank_we && bank_sel == 3'(b)) begin
          saved_bank[b] <= write_saved;
        end
      end
    end
  endgenerate

  // result of a status read: chosen word, or zero when no saved word exists
  wire [31:0] read_word = pick_saved ? saved_cur : cur_status;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      instr <= 32'h00000000;
      src_value <= 32'h00000000;
      rn_value <= 32'h00000000;
      result <= 32'h00000000;
      info <= 12'h000;
    end else begin
      if (wr_src) begin
        src_value <= hwdata;
      end
      if (wr_rn) begin
        rn_value <= hwdata;
      end
      if (do_read) begin
        result <= read_word;
      end
      if (wr_instr) begin
        instr <= hwdata;
        info <= {rd_idx, pc_used, saved_fault, (kind == srt_pkg::SRT_KIND_OTHER),
                 do_compare, do_write, do_read, ~cond_true, go};
      end
    end
  end

  // read data mux; unmapped offsets read as zero
  wire [31:0] rd_mux = (dp_addr == `SRT_OFS_INSTR) ? instr :
                       (dp_addr == `SRT_OFS_SRC) ? src_value :
                       (dp_addr == `SRT_OFS_RN) ? rn_value :
                       (dp_addr == `SRT_OFS_STATUS) ? cur_status :
                       (dp_addr == `SRT_OFS_SAVED) ? saved_cur :
                       (dp_addr == `SRT_OFS_RESULT) ? result :
                       (dp_addr == `SRT_OFS_INFO) ? {20'h00000, info} : 32'h00000000;

  // one wait state on reads keeps hrdata a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (rd_phase && !rd_done) begin
      hrdata <= rd_mux;
    end
  end

endmodule

// *** bench/srt_unit_chk.sv ***
// checker for the status transfer unit, bound to its top-level ports
// assumes hready is tied to hreadyout and one master on the bus
`timescale 1ns/1ns
module srt_unit_chk (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus side
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // core side
  input wire logic [31:0] status_word
);
  logic d;
  logic r;
  wire tk = hsel && hready && htrans[1];
  wire [31:0] w = hwdata;
  wire cl = w[27:26] == 2'h0 && w[24:23] == 2'h2;
  wire al = cl && w[31:28] == 4'he;
  wire wr = al && !w[20] && w[21];
  wire [63:0] dd = {24'h0, w[7:0], 24'h0, w[7:0]};
  wire [31:0] im = dd[{w[11:8], 1'b0} +: 32];
  wire usr = status_word[4:0] == 5'h10;
  // d marks the data phase of an instruction write, r that of any read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      d <= 1'b0;
      r <= 1'b0;
    end else begin
      d <= tk && hwrite && haddr[7:2] == 6'h0;
      r <= tk && !hwrite;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  cond_skip_a: assert property (d && cl && w[31:28] == 4'hf |=> $stable(status_word))
    else $error("status changed under a false condition");
  class_only_a: assert property (d && !cl |=> $stable(status_word))
    else $error("status changed by a foreign instruction");
  read_keep_a: assert property (d && al && !w[20] && !w[21] |=> $stable(status_word))
    else $error("status read altered the status word");
  idle_hold_a: assert property (!d |=> $stable(status_word))
    else $error("status changed without an instruction");
  flags_only_a: assert property (d && wr && !w[22] && !w[16] && w[25] |=>
    status_word == {$past(im[31:28]), $past(status_word[27:0])})
    else $error("flags-only write wrong");
  user_ctrl_a: assert property (d && wr && usr |=> $past(status_word[27:0]) == status_word[27:0])
    else $error("user mode changed control bits");
  priv_full_a: assert property (d && wr && !usr && !w[22] && w[16] && w[25] |=>
    status_word == $past(im))
    else $error("privileged full write wrong");
  saved_sel_a: assert property (d && wr && w[22] |=> $stable(status_word))
    else $error("saved write touched the current word");
  compare_ctrl_a: assert property (d && al && w[20] |=> $stable(status_word[27:0]))
    else $error("compare touched control bits");
  rd_wait_a: assert property (r |-> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  okay_resp_a: assert property (hresp == 1'b0)
    else $error("response not okay");
  cover property (d && wr && w[22]);
  cover property (d && wr && usr);
  cover property (d && al && w[20]);
endmodule

bind srt_unit srt_unit_chk i_srt_unit_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .hreadyout, .hresp, .status_word);

// *** bench/srt_unit_tb.sv ***
// self-checking bench for the status transfer unit with a behavioural model
// assumes the unit answers over ahb-lite with hready tied to hreadyout
`timescale 1ns/1ns
module srt_unit_tb;
  logic hclk, hresetn, hsel, hwrite;
  logic [31:0] haddr, hwdata;
  logic [1:0] htrans;
  wire hreadyout, hresp;
  wire [31:0] hrdata, status_word;
  int errors, n_compared;
  logic [31:0] st, res, q, src, rn, ins;
  logic [31:0] bank [logic [4:0]];
  logic [32:0] s;
  logic [4:0] modes [5] = '{5'h11, 5'h12, 5'h13, 5'h17, 5'h1b};
  srt_unit i_srt_unit (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .status_word(status_word));
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  task automatic report_and_stop();
    if (errors == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // waits for hready; a stuck slave ends the run
  task automatic wt();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 20);
    if (hreadyout !== 1'b1) begin
      errors++;
      report_and_stop();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wt();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wt();
    q = hrdata;
  endtask
  function automatic logic ok(input logic [3:0] c, input logic [3:0] f);
    logic n, z, cy, v;
    logic [15:0] t;
    {n, z, cy, v} = f;
    t = {1'b0, 1'b1, z | (n ^ v), !z & !(n ^ v), n ^ v, !(n ^ v), !cy | z, cy & !z,
      !v, v, !n, n, !cy, cy, !z, z};
    return t[c];
  endfunction
  function automatic logic [31:0] sv();
    return bank.exists(st[4:0]) ? bank[st[4:0]] : 32'h0;
  endfunction
  task automatic model(input logic [31:0] i);
    logic [31:0] o;
    logic [4:0] m;
    m = st[4:0];
    o = ({24'h0, i[7:0]} >> (2 * i[11:8])) | ({24'h0, i[7:0]} << (32 - 2 * i[11:8]));
    if (!i[25])
      o = src;
    if (i[27:26] != 2'h0 || i[24:23] != 2'h2 || !ok(i[31:28], st[31:28]))
      return;
    if (i[20]) begin
      case (i[22:21])
        2'h0: s = {1'b0, rn & o};
        2'h1: s = {1'b0, rn ^ o};
        2'h2: s = {1'b0, rn} + {1'b0, ~o} + 33'h1;
        default: s = {1'b0, rn} + {1'b0, o};
      endcase
      st[31:30] = {s[31], s[31:0] == 32'h0};
      if (i[22]) begin
        st[29] = s[32];
        st[28] = (rn[31] ^ o[31] ^ i[21]) && (s[31] ^ rn[31]);
      end else if (i[25] && i[11:8] != 4'h0)
        st[29] = o[31];
    end else if (!i[21])
      res = i[22] ? sv() : st;
    else if (i[22]) begin
      if (bank.exists(m))
        bank[m] = i[16] ? o : {o[31:28], bank[m][27:0]};
    end else
      st = (i[16] && m != 5'h10) ? o : {o[31:28], st[27:0]};
  endtask
  task automatic gen(input bit usr);
    ins = $urandom;
    src = $urandom;
    rn = $urandom;
    src[5:0] = {1'b0, modes[$urandom_range(4, 0)]};
    ins[27:23] = {2'h0, ins[25], 2'h2};
    ins[19] = 1'b0;
    ins[15] = 1'b0;
    if ($urandom_range(3, 0) != 0)
      ins[31:28] = 4'he;
    if ($urandom_range(7, 0) == 0)
      ins[26] = 1'b1;
    if (usr)
      ins[22] = 1'b0;
    if (!ins[20] && ins[21] && !ins[22] && ins[16])
      ins[11:0] = {6'h0, src[5:0]};
  endtask
  task automatic run(input logic [31:0] i);
    bus(1'b1, 8'h04, src);
    bus(1'b1, 8'h08, rn);
    bus(1'b1, 8'h00, i);
    model(i);
    bus(1'b0, 8'h0c, 32'h0);
    chk(q, st);
    bus(1'b0, 8'h10, 32'h0);
    chk(q, sv());
    bus(1'b0, 8'h14, 32'h0);
    chk(q, res);
  endtask
  task automatic rst();
    hresetn <= 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    st = 32'h000000d3;
    res = 32'h0;
    bank.delete();
    foreach (modes[k])
      bank[modes[k]] = 32'h0;
  endtask
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    errors = 0;
    n_compared = 0;
    void'($urandom(79237));
    rst();
    bus(1'b1, 8'h0c, 32'h0);
    bus(1'b0, 8'h0c, 32'h0);
    chk(q, 32'h000000d3);
    bus(1'b0, 8'h1c, 32'h0);
    chk(q, 32'h0);
    repeat (300) begin
      gen(1'b0);
      run(ins);
    end
    src = 32'h10;
    run(32'he1290000);
    repeat (60) begin
      gen(1'b1);
      run(ins);
    end
    rst();
    bus(1'b0, 8'h0c, 32'h0);
    chk(q, st);
    report_and_stop();
  end
endmodule
